// ---- rtl/pld_pkg.sv ----
// package: constants, modes and config layouts of the macrocell and io cell block
package pld_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_MC      = 4;
  localparam int PT_PER_MC   = 5;
  localparam int PT_TOTAL    = NUM_MC * PT_PER_MC;
  localparam int NUM_IO      = 8;
  localparam int NUM_DED     = 4;
  localparam int VEC_W       = NUM_DED + NUM_MC + NUM_IO;
  localparam int ROW_CH      = 96;
  localparam int COL_CH      = 3;
  localparam int NUM_GCLK    = 2;
  localparam int NUM_POE     = 8;
  localparam int NUM_PCLK    = 4;
  localparam int NUM_PCE     = 6;
  localparam int NUM_PCLR    = 2;
  localparam int PSEL_W      = 4;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_GCTRL   = 12'h000;
  localparam logic [11:0] ADDR_POE     = 12'h004;
  localparam logic [11:0] ADDR_PCLKCLR = 12'h008;
  localparam logic [11:0] ADDR_PCE     = 12'h00c;
  localparam logic [11:0] ADDR_MC_BASE = 12'h010;
  localparam logic [11:0] ADDR_IO_BASE = 12'h020;
  localparam logic [11:0] ADDR_PT_BASE = 12'h040;
  localparam logic [11:0] ADDR_STATUS  = 12'h090;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PT_TRUE_LSB = 0;
  localparam int PT_COMP_LSB = 16;
  localparam int PCLR_LSB    = 16;
  localparam int PT_PACK_D   = 0;
  localparam int PT_AUX      = 1;
  localparam int PT_CLK      = 2;
  localparam int PT_PRE      = 3;
  localparam int PT_CLR      = 4;
  localparam logic [6:0] ROW_DED_BASE = 7'h5c;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [5:0]  GCTRL_RST  = 6'h00;
  localparam logic [31:0] PERIPH_RST = 32'h0000_0000;
  localparam logic [31:0] MC_CFG_RST = 32'h0000_0000;
  localparam logic [15:0] IO_CFG_RST = 16'h0000;
  localparam logic [31:0] PT_RST     = 32'h0000_0000;

  // ----------------------------------------------------------------
  // modes and layouts
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {FF_D, FF_T, FF_JK, FF_SR} pld_ff_t;
  typedef enum logic [1:0] {CLK_GLOBAL, CLK_GLOBAL_EN, CLK_ARRAY, CLK_RSVD} pld_clk_t;
  typedef enum logic [1:0] {DIR_IN, DIR_OUT, DIR_BIDIR, DIR_RSVD} pld_dir_t;
  typedef enum logic [1:0] {IOREG_NONE, IOREG_IN, IOREG_OUT, IOREG_RSVD} pld_ioreg_t;

  typedef struct packed {
    logic       dedRowEn;
    logic       gclrActiveHigh;
    logic       gclk1Inv;
    logic       gclk1PinSel;
    logic       gclk0Inv;
    logic       gclk0PinSel;
  } pld_gctrl_t;

  typedef struct packed {
    logic [3:0] expMask;
    logic [4:0] lendMask;
    logic [1:0] colIdx;
    logic [6:0] rowIdx;
    logic       colEn;
    logic       rowEn;
    logic       globalSelComb;
    logic       localSelComb;
    logic       clearEn;
    logic       presetEn;
    logic       packEn;
    logic       useGlobalClr;
    logic       gclkSel;
    pld_clk_t   clkMode;
    logic       bypass;
    pld_ff_t    ffType;
  } pld_mc_cfg_t;

  typedef struct packed {
    logic       ceEn;
    logic       clrSel;
    logic [2:0] ceSel;
    logic [1:0] clkSel;
    logic [2:0] oeSel;
    logic [1:0] dataSel;
    pld_ioreg_t regUse;
    pld_dir_t   dir;
  } pld_io_cfg_t;

endpackage : pld_pkg

// ---- rtl/pld_cell_top.sv ----
// macrocell array, io cells, routing and apb configuration port
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/100ps

module pld_cell_top
  import pld_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                reset_n,
  input  wire logic [11:0]         paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  input  wire logic                globalClockPinA,
  input  wire logic                globalClockPinB,
  input  wire logic                globalClearPin,
  input  wire logic                dedicatedInput4,
  input  wire logic [NUM_IO-1:0]   ioPinIn,
  output logic [NUM_IO-1:0]        ioPinOut,
  output logic [NUM_IO-1:0]        ioPinOe,
  output logic [ROW_CH-1:0]        rowChannels,
  output logic [COL_CH-1:0]        colChannels
);

  // ----------------------------------------------------------------
  // configuration state
  // ----------------------------------------------------------------
  pld_gctrl_t             gctrl_reg;
  logic        [31:0]     poeWord_reg;
  logic        [31:0]     pclkclrWord_reg;
  logic        [31:0]     pceWord_reg;
  pld_mc_cfg_t            mcCfg_reg [NUM_MC];
  pld_io_cfg_t            ioCfg_reg [NUM_IO];
  logic        [31:0]     ptMask_reg [PT_TOTAL];

  // ----------------------------------------------------------------
  // shared nets
  // ----------------------------------------------------------------
  logic [NUM_DED-1:0]  dedPins;
  logic [VEC_W-1:0]    pinVec;
  logic [PT_TOTAL-1:0] ptVal;
  logic [NUM_MC-1:0]   mcQ;
  logic [NUM_MC-1:0]   mcComb;
  logic [NUM_MC-1:0]   mcGlobal;
  logic [NUM_MC-1:0]   mcLocal;
  logic [NUM_MC-1:0]   lentAny;
  logic [NUM_IO-1:0]   ioInVal;
  logic [NUM_IO-1:0]   ioRegQ;
  logic [NUM_GCLK-1:0] gclkNet;
  logic [NUM_GCLK-1:0] gclkPrev_reg;
  logic [NUM_GCLK-1:0] gclkEdge;
  logic                gclrActive;
  logic [NUM_POE-1:0]  periphOe;
  logic [NUM_PCLK-1:0] periphClk;
  logic [NUM_PCLK-1:0] pclkPrev_reg;
  logic [NUM_PCLK-1:0] pclkEdge;
  logic [NUM_PCE-1:0]  periphCe;
  logic [NUM_PCLR-1:0] periphClr;
  logic [ROW_CH-1:0]   rowNext;
  logic [COL_CH-1:0]   colNext;

  // dedicated pins double as data into the array and row routing
  assign dedPins = {dedicatedInput4, globalClearPin, globalClockPinB, globalClockPinA};
  // local feedback is always a flop, so the array has no combinational loop
  assign pinVec  = {ioInVal, mcLocal, dedPins};

  // ----------------------------------------------------------------
  // global clocks and clear
  // ----------------------------------------------------------------
  // pins are sampled on clk_sys; a global clock edge is a one-cycle enable
  assign gclkNet[0] = (gctrl_reg.gclk0PinSel ? globalClockPinB : globalClockPinA)
                      ^ gctrl_reg.gclk0Inv;
  assign gclkNet[1] = (gctrl_reg.gclk1PinSel ? globalClockPinB : globalClockPinA)
                      ^ gctrl_reg.gclk1Inv;
  assign gclkEdge   = gclkNet & ~gclkPrev_reg;
  assign gclrActive = gctrl_reg.gclrActiveHigh ? globalClearPin : ~globalClearPin;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      gclkPrev_reg <= '0;
      pclkPrev_reg <= '0;
    end
    else
    begin
      gclkPrev_reg <= gclkNet;
      pclkPrev_reg <= periphClk;
    end
  end

  // ----------------------------------------------------------------
  // peripheral control bus
  // ----------------------------------------------------------------
  // every line picks any dedicated pin, macrocell or io input
  always_comb
  begin
    for (int k = 0; k < NUM_POE; k++)
      periphOe[k] = pinVec[poeWord_reg[PSEL_W*k +: PSEL_W]];
    for (int k = 0; k < NUM_PCLK; k++)
      periphClk[k] = pinVec[pclkclrWord_reg[PSEL_W*k +: PSEL_W]];
    for (int k = 0; k < NUM_PCLR; k++)
      periphClr[k] = pinVec[pclkclrWord_reg[PCLR_LSB + PSEL_W*k +: PSEL_W]];
    for (int k = 0; k < NUM_PCE; k++)
      periphCe[k] = pinVec[pceWord_reg[PSEL_W*k +: PSEL_W]];
  end
  assign pclkEdge = periphClk & ~pclkPrev_reg;

  // ----------------------------------------------------------------
  // product terms
  // ----------------------------------------------------------------
  // an all-zero mask means the term is unused and reads low
  for (genvar p = 0; p < PT_TOTAL; p++)
  begin : gen_pt
    assign ptVal[p] = (|ptMask_reg[p])
                      & (&(~ptMask_reg[p][PT_TRUE_LSB +: VEC_W] | pinVec))
                      & (&(~ptMask_reg[p][PT_COMP_LSB +: VEC_W] | ~pinVec));
  end

  // ----------------------------------------------------------------
  // macrocells
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_MC; g++)
  begin : gen_mc
    pld_mc_cfg_t            cfg;
    logic [PT_PER_MC-1:0]   ptOwn;
    logic [PT_PER_MC-1:0]   claimed;
    logic                   expSum;
    logic                   sum;
    logic                   dIn;
    logic                   aux;
    logic                   clkEvent;
    logic                   presetHit;
    logic                   clearHit;
    logic                   qNext;
    logic                   q_reg;
    logic                   ptClkPrev_reg;
    logic                   combFb_reg;

    assign cfg        = mcCfg_reg[g];
    assign ptOwn      = ptVal[g*PT_PER_MC +: PT_PER_MC];
    assign lentAny[g] = |(ptOwn & cfg.lendMask);

    always_comb
    begin
      claimed = '0;
      if (!cfg.bypass && (cfg.ffType == FF_JK || cfg.ffType == FF_SR))
        claimed[PT_AUX] = 1'b1;
      if (!cfg.bypass && cfg.clkMode != CLK_GLOBAL)
        claimed[PT_CLK] = 1'b1;
      if (cfg.presetEn)
        claimed[PT_PRE] = 1'b1;
      if (cfg.clearEn)
        claimed[PT_CLR] = 1'b1;
      if (cfg.packEn)
        claimed[PT_PACK_D] = 1'b1;
      // borrowed terms: up to three neighbours of five terms each
      expSum = 1'b0;
      for (int j = 0; j < NUM_MC; j++)
        if (j != g && cfg.expMask[j])
          expSum = expSum | lentAny[j];
      sum = (|(ptOwn & ~claimed & ~cfg.lendMask)) | expSum;
    end

    assign dIn = cfg.packEn ? ptOwn[PT_PACK_D] : sum;
    assign aux = ptOwn[PT_AUX];

    always_comb
    begin
      case (cfg.clkMode)
        CLK_GLOBAL:    clkEvent = gclkEdge[cfg.gclkSel];
        CLK_GLOBAL_EN: clkEvent = gclkEdge[cfg.gclkSel] & ptOwn[PT_CLK];
        CLK_ARRAY:     clkEvent = ptOwn[PT_CLK] & ~ptClkPrev_reg;
        default:       clkEvent = 1'b0;
      endcase
    end

    assign presetHit = cfg.presetEn & ptOwn[PT_PRE];
    assign clearHit  = (cfg.clearEn & ptOwn[PT_CLR])
                       | (cfg.useGlobalClr & gclrActive);

    always_comb
    begin
      qNext = q_reg;
      if (clearHit)
        qNext = 1'b0;
      else if (presetHit)
        qNext = 1'b1;
      else if (clkEvent)
      begin
        case (cfg.ffType)
          FF_D:    qNext = dIn;
          FF_T:    qNext = q_reg ^ dIn;
          FF_JK:   qNext = (dIn & ~q_reg) | (~aux & q_reg);
          FF_SR:   qNext = dIn ? (aux ? q_reg : 1'b1) : (aux ? 1'b0 : q_reg);
          default: qNext = q_reg;
        endcase
      end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
      if (!reset_n)
      begin
        q_reg         <= 1'b0;
        ptClkPrev_reg <= 1'b0;
        combFb_reg    <= 1'b0;
      end
      else
      begin
        q_reg         <= qNext;
        ptClkPrev_reg <= ptOwn[PT_CLK];
        combFb_reg    <= sum;
      end
    end

    assign mcQ[g]      = q_reg;
    assign mcComb[g]   = sum;
    // bypass forces the sum onto the global output and its registered copy onto the local output
    assign mcGlobal[g] = (cfg.bypass | cfg.globalSelComb) ? sum : q_reg;
    assign mcLocal[g]  = (cfg.bypass | cfg.localSelComb) ? combFb_reg : q_reg;
  end

  // ----------------------------------------------------------------
  // io cells
  // ----------------------------------------------------------------
  for (genvar k = 0; k < NUM_IO; k++)
  begin : gen_io
    pld_io_cfg_t  cfg;
    logic         dataOut;
    logic         ce;
    logic         capture;
    logic         ioReg_reg;
    logic         pinOut_reg;
    logic         pinOe_reg;

    assign cfg     = ioCfg_reg[k];
    assign dataOut = mcGlobal[cfg.dataSel];
    // enable lines beyond the sixth read as low
    assign ce      = !cfg.ceEn
                     || (int'(cfg.ceSel) < NUM_PCE && periphCe[cfg.ceSel]);
    assign capture = pclkEdge[cfg.clkSel] & ce;

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
      if (!reset_n)
        ioReg_reg <= 1'b0;
      else if (periphClr[cfg.clrSel])
        ioReg_reg <= 1'b0;
      else if (capture && cfg.regUse == IOREG_IN)
        ioReg_reg <= ioPinIn[k];
      else if (capture && cfg.regUse == IOREG_OUT)
        ioReg_reg <= dataOut;
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
      if (!reset_n)
      begin
        pinOut_reg <= 1'b0;
        pinOe_reg  <= 1'b0;
      end
      else
      begin
        pinOut_reg <= (cfg.regUse == IOREG_OUT) ? ioReg_reg : dataOut;
        case (cfg.dir)
          DIR_OUT:   pinOe_reg <= 1'b1;
          DIR_BIDIR: pinOe_reg <= periphOe[cfg.oeSel];
          default:   pinOe_reg <= 1'b0;
        endcase
      end
    end

    assign ioInVal[k]  = (cfg.regUse == IOREG_IN) ? ioReg_reg : ioPinIn[k];
    assign ioRegQ[k]   = ioReg_reg;
    assign ioPinOut[k] = pinOut_reg;
    assign ioPinOe[k]  = pinOe_reg;
  end

  // ----------------------------------------------------------------
  // row and column routing
  // ----------------------------------------------------------------
  // channels are wired-or; two drivers on one channel is a config error
  always_comb
  begin
    rowNext = '0;
    colNext = '0;
    for (int g = 0; g < NUM_MC; g++)
    begin
      for (int c = 0; c < ROW_CH; c++)
        if (mcCfg_reg[g].rowEn && mcCfg_reg[g].rowIdx == 7'(c))
          rowNext[c] = rowNext[c] | mcGlobal[g];
      for (int c = 0; c < COL_CH; c++)
        if (mcCfg_reg[g].colEn && mcCfg_reg[g].colIdx == 2'(c))
          colNext[c] = colNext[c] | mcGlobal[g];
    end
    if (gctrl_reg.dedRowEn)
      for (int d = 0; d < NUM_DED; d++)
        rowNext[ROW_DED_BASE + 7'(d)] = rowNext[ROW_DED_BASE + 7'(d)] | dedPins[d];
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rowChannels <= '0;
      colChannels <= '0;
    end
    else
    begin
      rowChannels <= rowNext;
      colChannels <= colNext;
    end
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic        rdHit;
  logic [31:0] rdData;
  logic        ptSel;
  logic [5:0]  ptWord;
  logic [4:0]  ptIdx;
  logic        wrStrobe;

  assign ptWord   = paddr[7:2] - ADDR_PT_BASE[7:2];
  assign ptSel    = paddr[11:8] == 4'h0 && paddr[7:2] >= ADDR_PT_BASE[7:2]
                    && ptWord < 6'(PT_TOTAL);
  assign ptIdx    = ptWord[4:0];
  assign wrStrobe = psel & penable & pready & pwrite & rdHit;

  always_comb
  begin
    rdHit  = 1'b1;
    rdData = 32'h0000_0000;
    if (ptSel)
      rdData = ptMask_reg[ptIdx];
    else if (paddr[11:4] == ADDR_MC_BASE[11:4])
      rdData = mcCfg_reg[paddr[3:2]];
    else if (paddr[11:5] == ADDR_IO_BASE[11:5])
      rdData = {16'h0000, ioCfg_reg[paddr[4:2]]};
    else
    begin
      case ({paddr[11:2], 2'b00})
        ADDR_GCTRL:   rdData = {26'h0000000, gctrl_reg};
        ADDR_POE:     rdData = poeWord_reg;
        ADDR_PCLKCLR: rdData = pclkclrWord_reg;
        ADDR_PCE:     rdData = pceWord_reg;
        ADDR_STATUS:  rdData = {8'h00, ioRegQ, ioInVal, mcComb, mcQ};
        default:      rdHit  = 1'b0;
      endcase
    end
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel && penable && !pready)
    begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h0000_0000 : rdData;
      pslverr <= !rdHit;
    end
    else
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      gctrl_reg       <= GCTRL_RST;
      poeWord_reg     <= PERIPH_RST;
      pclkclrWord_reg <= PERIPH_RST;
      pceWord_reg     <= PERIPH_RST;
      for (int i = 0; i < NUM_MC; i++)
        mcCfg_reg[i] <= MC_CFG_RST;
      for (int i = 0; i < NUM_IO; i++)
        ioCfg_reg[i] <= IO_CFG_RST;
      for (int i = 0; i < PT_TOTAL; i++)
        ptMask_reg[i] <= PT_RST;
    end
    else if (wrStrobe)
    begin
      if (ptSel)
        ptMask_reg[ptIdx] <= pwdata;
      else if (paddr[11:4] == ADDR_MC_BASE[11:4])
        mcCfg_reg[paddr[3:2]] <= pld_mc_cfg_t'(pwdata);
      else if (paddr[11:5] == ADDR_IO_BASE[11:5])
        ioCfg_reg[paddr[4:2]] <= pld_io_cfg_t'(pwdata[15:0]);
      else
      begin
        case ({paddr[11:2], 2'b00})
          ADDR_GCTRL:   gctrl_reg       <= pld_gctrl_t'(pwdata[5:0]);
          ADDR_POE:     poeWord_reg     <= pwdata;
          ADDR_PCLKCLR: pclkclrWord_reg <= pwdata;
          ADDR_PCE:     pceWord_reg     <= pwdata;
          default:      ;
        endcase
      end
    end
  end

endmodule : pld_cell_top

// ---- verification/pld_cell_top_asserts.sv ----
// assertion checker for the apb port and pin outputs of the cell block
`timescale 1ns/100ps
module pld_cell_top_asserts
  import pld_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              reset_n,
  input wire logic [11:0]       paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  input wire logic              globalClockPinA,
  input wire logic              globalClockPinB,
  input wire logic              globalClearPin,
  input wire logic              dedicatedInput4,
  input wire logic [NUM_IO-1:0] ioPinOe,
  input wire logic [ROW_CH-1:0] rowChannels
);
  // ------------------------------------------------------------
  // shadow of the config the pin checks depend on
  // ------------------------------------------------------------
  logic [NUM_IO-1:0] inMask;
  logic [NUM_IO-1:0] outMask;
  logic              dedRow;
  logic [3:0]        dedPins;
  assign dedPins = {dedicatedInput4, globalClearPin, globalClockPinB, globalClockPinA};

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      inMask  <= '1;
      outMask <= '0;
      dedRow  <= 1'b0;
    end
    else if (psel && penable && pready && pwrite)
    begin
      if (paddr[11:5] == ADDR_IO_BASE[11:5])
      begin
        inMask[paddr[4:2]]  <= pwdata[1:0] == DIR_IN;
        outMask[paddr[4:2]] <= pwdata[1:0] == DIR_OUT;
      end
      if (paddr[11:2] == ADDR_GCTRL[11:2])
        dedRow <= pwdata[5];
    end
  end

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  sequence s_one_wait;
    !pready ##1 pready;
  endsequence

  apb_one_wait_a: assert property (psel && penable && !$past(penable) |-> s_one_wait)
    else $error("answer not after one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_cause_a: assert property (pready |-> psel && penable && $past(penable))
    else $error("pready without access phase");
  idle_quiet_a: assert property (!pready |-> prdata == '0 && !pslverr)
    else $error("data or error outside answer");
  unmapped_err_a: assert property (pready && paddr[11:2] > 10'h024 |-> pslverr && prdata == '0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (pready && paddr[11:2] <= 10'h024 |-> !pslverr)
    else $error("mapped access refused");
  input_no_drive_a: assert property ((ioPinOe & $past(inMask)) == '0)
    else $error("input pin driven");
  output_drive_a: assert property ((~ioPinOe & $past(outMask)) == '0)
    else $error("output pin not driven");
  ded_row_a: assert property ($past(dedRow) && $stable(dedPins)
    |-> (dedPins & ~rowChannels[95:92]) == '0)
    else $error("dedicated pin missing on row");
endmodule : pld_cell_top_asserts

bind pld_cell_top pld_cell_top_asserts u_asserts (.clk_sys(clk_sys), .reset_n(reset_n),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .globalClockPinA(globalClockPinA),
  .globalClockPinB(globalClockPinB), .globalClearPin(globalClearPin),
  .dedicatedInput4(dedicatedInput4), .ioPinOe(ioPinOe), .rowChannels(rowChannels));

// ---- verification/pld_pin_model.sv ----
// model of the circuitry on the general-purpose pins
`timescale 1ns/100ps
module pld_pin_model
  import pld_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic [NUM_IO-1:0] ioPinOut,
  input  wire logic [NUM_IO-1:0] ioPinOe,
  input  wire logic [NUM_IO-1:0] extVal,
  input  wire logic [NUM_IO-1:0] extOe,
  output logic      [NUM_IO-1:0] ioPinIn
);
  logic [NUM_IO-1:0] floatVal = '0;

  // a pin nobody drives has no trusted level, so flip it each cycle
  always @(posedge clk_sys)
    floatVal <= ~ioPinIn;

  always_comb
    for (int k = 0; k < NUM_IO; k++)
      ioPinIn[k] = ioPinOe[k] ? ioPinOut[k] : (extOe[k] ? extVal[k] : floatVal[k]);
endmodule : pld_pin_model

// ---- verification/pld_cell_top_tb.sv ----
// self-checking bench for the macrocell and io cell block
`timescale 1ns/100ps
module pld_cell_top_tb;
  import pld_pkg::*;
  logic        clk_sys = 1'b0, reset_n = 1'b0, err;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pinA = 1'b0, pinB = 1'b0, clrPin = 1'b0, ded4 = 1'b0;
  logic [7:0]  ioPinIn, ioPinOut, ioPinOe, extVal = '0, extOe = '0;
  logic [95:0] rowChannels;
  logic [2:0]  colChannels;
  pld_mc_cfg_t mc;
  pld_io_cfg_t io;
  int          errors = 0, n_tests = 0, cycles = 0;

  always #50 clk_sys = ~clk_sys;

  pld_cell_top DUT (.clk_sys(clk_sys), .reset_n(reset_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .globalClockPinA(pinA), .globalClockPinB(pinB),
    .globalClearPin(clrPin), .dedicatedInput4(ded4), .ioPinIn(ioPinIn), .ioPinOut(ioPinOut),
    .ioPinOe(ioPinOe), .rowChannels(rowChannels), .colChannels(colChannels));
  pld_pin_model PINS (.clk_sys(clk_sys), .ioPinOut(ioPinOut), .ioPinOe(ioPinOe),
    .extVal(extVal), .extOe(extOe), .ioPinIn(ioPinIn));

  // ------------------------------------------------------------
  // bus and check tasks
  // ------------------------------------------------------------
  task automatic finish_test;
    $display("errors=%0d checks=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one idle cycle after each transfer keeps psel from being driven twice per step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
      @(posedge clk_sys);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task automatic pulse(input logic [1:0] p);
    {pinB, pinA} <= p;
    repeat (3) @(posedge clk_sys);
    {pinB, pinA} <= 2'b00;
    repeat (3) @(posedge clk_sys);
  endtask : pulse

  task automatic chkQ(input logic e);
    apb(1'b0, ADDR_STATUS, '0);
    chk(32'(rd[0]), 32'(e));
  endtask : chkQ

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    logic [11:0] regs [5] = '{ADDR_GCTRL, ADDR_POE, ADDR_MC_BASE, ADDR_IO_BASE, ADDR_PT_BASE};
    chk(32'({ioPinOe, ioPinOut}), '0);
    foreach (regs[i])
    begin
      apb(1'b0, regs[i], '0);
      chk(rd, '0);
    end
    apb(1'b1, 12'h0a0, 32'hffff_ffff);
    chk(32'(err), 32'h1);
    apb(1'b0, 12'h0a0, '0);
    chk(rd | 32'(!err), '0);
  endtask : t_reset

  task automatic t_clocks;
    pld_ff_t modes [3] = '{FF_T, FF_JK, FF_SR};
    logic q = 1'b1;
    apb(1'b1, ADDR_PT_BASE, 32'h0000_0008);
    ded4 <= 1'b1;
    pulse(2'b01);
    chkQ(1'b1);
    apb(1'b1, ADDR_GCTRL, 32'h0000_0001);
    ded4 <= 1'b0;
    pulse(2'b01);
    chkQ(1'b1);
    pulse(2'b10);
    chkQ(1'b0);
    apb(1'b1, ADDR_GCTRL, 32'h0000_0003);
    ded4 <= 1'b1;
    pulse(2'b10);
    chkQ(1'b1);
    apb(1'b1, ADDR_GCTRL, '0);
    apb(1'b1, ADDR_PT_BASE + 12'h004, 32'h0000_0008);
    foreach (modes[i])
    begin
      mc = '0;
      mc.ffType = modes[i];
      apb(1'b1, ADDR_MC_BASE, mc);
      pulse(2'b01);
      q = (modes[i] == FF_SR) ? q : ~q;
      chkQ(q);
    end
  endtask : t_clocks

  task automatic t_enable;
    mc = '0;
    mc.clkMode = CLK_GLOBAL_EN;
    apb(1'b1, ADDR_PT_BASE + 12'h008, 32'h0000_0004);
    apb(1'b1, ADDR_MC_BASE, mc);
    ded4 <= 1'b0;
    pulse(2'b01);
    chkQ(1'b1);
    clrPin <= 1'b1;
    pulse(2'b01);
    chkQ(1'b0);
    clrPin <= 1'b0;
    ded4 <= 1'b1;
    mc.clkMode = CLK_ARRAY;
    apb(1'b1, ADDR_MC_BASE, mc);
    pulse(2'b01);
    chkQ(1'b0);
    clrPin <= 1'b1;
    chkQ(1'b1);
  endtask : t_enable

  task automatic t_preclr;
    apb(1'b1, ADDR_PT_BASE + 12'h00c, 32'h0000_0008);
    apb(1'b1, ADDR_PT_BASE + 12'h010, 32'h0000_0008);
    mc = '0;
    mc.presetEn = 1'b1;
    mc.clearEn = 1'b1;
    apb(1'b1, ADDR_MC_BASE, mc);
    chkQ(1'b0);
    mc.clearEn = 1'b0;
    apb(1'b1, ADDR_MC_BASE, mc);
    chkQ(1'b1);
    mc.presetEn = 1'b0;
    mc.useGlobalClr = 1'b1;
    apb(1'b1, ADDR_MC_BASE, mc);
    chkQ(1'b1);
    clrPin <= 1'b0;
    chkQ(1'b0);
    apb(1'b1, ADDR_GCTRL, 32'h0000_0010);
    pulse(2'b01);
    chkQ(1'b1);
  endtask : t_preclr

  task automatic t_pins;
    clrPin <= 1'b1;
    apb(1'b1, ADDR_GCTRL, 32'h0000_0020);
    pulse(2'b01);
    io = '0;
    io.dir = DIR_OUT;
    apb(1'b1, ADDR_IO_BASE, 32'(io));
    // pin flops load one edge after the write lands
    @(posedge clk_sys);
    chk(32'({ioPinOe[0], ioPinOut[0]}), 32'h3);
    chk(32'(rowChannels[95:92]), 32'hc);
    extOe <= 8'h02;
    extVal <= 8'h02;
    apb(1'b0, ADDR_STATUS, '0);
    chk(32'({ioPinOe[1], rd[9]}), 32'h1);
    mc = '0;
    mc.rowEn = 1'b1;
    mc.colEn = 1'b1;
    mc.rowIdx = 7'h05;
    mc.colIdx = 2'h2;
    apb(1'b1, ADDR_MC_BASE, mc);
    @(posedge clk_sys);
    chk(32'({rowChannels[5], colChannels}), 32'hc);
    {ded4, clrPin} <= 2'b00;
    mc.bypass = 1'b1;
    apb(1'b1, ADDR_MC_BASE, mc);
    @(posedge clk_sys);
    chk(32'({ioPinOut[0], rowChannels[5], colChannels[2]}), '0);
    chkQ(1'b1);
  endtask : t_pins

  // ------------------------------------------------------------
  // main sequence and hang guard
  // ------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      $display("[ERR] %0t run did not finish", $time);
      finish_test();
    end
  end

  initial
  begin
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_clocks();
    t_enable();
    t_preclr();
    t_pins();
    finish_test();
  end
endmodule : pld_cell_top_tb
